// *** include/rwc_pkg.sv ***
// Purpose: shared constants and types for the reset and wake-up control
// Assumes: hclk at 20 MHz from the internal rc oscillator
// Notes:   offsets are byte addresses on the ahb-lite register port
package rwc_pkg;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned START_MS        = 18;
  localparam int unsigned START_CYC       = START_MS * (CLK_HZ / 1000);
  localparam int unsigned PIN_RST_CYC     = 1;
  localparam int unsigned WAKE_CYC        = 1;
  localparam int unsigned WDT_PERIOD_MS   = 18;
  localparam int unsigned WDT_CYC         = WDT_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W           = 20;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WAKE   = 8'h04;
  localparam logic [7:0] OFS_IRQEN  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CORE   = 8'h10;

  // ctrl bits
  localparam int unsigned CTRL_WDTE  = 0;
  localparam int unsigned CTRL_GIE   = 1;
  localparam int unsigned CTRL_MODE  = 2; // two bits
  localparam int unsigned CTRL_TCNT  = 4; // timer used as counter
  localparam int unsigned CTRL_W     = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  // wake enable bits
  localparam int unsigned WK_EXT  = 0;
  localparam int unsigned WK_PIN  = 1;
  localparam int unsigned WK_SER  = 2;
  localparam int unsigned WK_W    = 3;
  // irq enable bits
  localparam int unsigned IE_TMR  = 0;
  localparam int unsigned IE_EXT  = 1;
  localparam int unsigned IE_PIN  = 2;
  localparam int unsigned IE_STX  = 3;
  localparam int unsigned IE_SRX  = 4;
  localparam int unsigned IE_SER  = 5;
  localparam int unsigned IE_W    = 6;

  localparam logic [7:0] VEC_ADDR = 8'h09;
  localparam int unsigned NSRC    = 6;

  // operating modes
  typedef enum logic [1:0] {
    RWC_NORMAL = 2'd0,
    RWC_GREEN  = 2'd1,
    RWC_IDLE   = 2'd2,
    RWC_SLEEP  = 2'd3
  } rwc_mode_t;

  typedef enum logic [2:0] {
    RWC_ST_HOLD,
    RWC_ST_RUN,
    RWC_ST_DOWN,
    RWC_ST_WAKE,
    RWC_ST_PULSE
  } rwc_state_t;

endpackage : rwc_pkg

// *** rtl/rwc_sync.sv ***
// Purpose: two flip-flop synchroniser for a vector of levels
// Assumes: async inputs, single clock domain
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module rwc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] init,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // ---------------------------------------------------------------------
  // two stages
  // ---------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d ^ init;
      q      <= meta_q;
    end
  end
endmodule : rwc_sync

// *** rtl/rwc_top.sv ***
// Purpose: reset and wake-up sequencing with an ahb-lite register port
// Assumes: hclk 20 MHz from the internal rc oscillator; core and pins
//          driven by the same clock, wake sources may be asynchronous
// Notes:   port outputs are registered except hreadyout and hresp, which are tied off; long counts are parameters
`timescale 1ns/10ps

module rwc_top #(
  parameter int unsigned START_CYC = rwc_pkg::START_CYC,
  parameter int unsigned WDT_CYC   = rwc_pkg::WDT_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_reset_n,
  input  wire logic        power_down_instruction,
  input  wire logic        ext_pin_event,
  input  wire logic        pin_change_event,
  input  wire logic        timer_event,
  input  wire logic        serial_tx_done,
  input  wire logic        serial_rx_full,
  input  wire logic        serial_rx_error,
  output logic             core_reset,
  output logic             osc_run,
  output logic             port_force_input,
  output logic             resume_next,
  output logic             take_vector,
  output logic      [7:0]  vector_addr,
  output logic      [7:0]  program_counter_low,
  output logic      [7:0]  bank_select,
  output logic             flag_timeout,
  output logic             flag_power_down
);

  // ---------------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------------
  typedef struct packed {
    rwc_pkg::rwc_state_t          st;
    logic [rwc_pkg::CNT_W-1:0]    cnt;
    logic [rwc_pkg::CTRL_W-1:0]   ctrl;
    logic [rwc_pkg::WK_W-1:0]     wake_en;
    logic [rwc_pkg::IE_W-1:0]     irq_en;
    logic [7:0]                   pc;
    logic [7:0]                   bank;
    logic [7:0]                   core_reg;
    logic                         flag_t;
    logic                         flag_p;
    logic                         vec;
    logic                         nxt;
    logic                         wvec;
    logic [7:0]                   vaddr;
    logic                         wdt_clr;
    logic                         ph_wr;
    logic                         ph_rd;
    logic [7:0]                   ph_addr;
    logic [31:0]                  rdata;
    logic                         rst_out;
    logic                         port_in;
    logic                         osc;
  } rwc_state_rec_t;

  rwc_state_rec_t s_q;
  rwc_state_rec_t s_d;

  logic [rwc_pkg::NSRC-1:0] raw_src;
  logic [rwc_pkg::NSRC-1:0] src;
  logic                     wdt_to;
  logic                     pin_rst;
  logic                     ext_ev;
  logic                     chg_ev;
  logic                     tmr_ev;
  logic                     stx_ev;
  logic                     srx_ev;
  logic                     ser_ev;
  logic                     wdte;
  logic                     gie;
  rwc_pkg::rwc_mode_t       mode;
  logic                     low_pwr;
  logic                     wake_any;
  logic                     irq_any;
  logic                     irq_pend;

  // ---------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------
  // reset pin is inverted so that the idle level is zero
  assign raw_src = {serial_rx_error, serial_rx_full, serial_tx_done,
                    timer_event, pin_change_event, ext_pin_event};

  rwc_sync #(.W(rwc_pkg::NSRC + 1)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({ext_reset_n, raw_src}),
    .init    ({1'b1, {rwc_pkg::NSRC{1'b0}}}),
    .q       ({pin_rst, src})
  );

  assign ext_ev = src[0];
  assign chg_ev = src[1];
  assign tmr_ev = src[2];
  assign stx_ev = src[3];
  assign srx_ev = src[4];
  assign ser_ev = src[5];

  // ---------------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------------
  assign wdte = s_q.ctrl[rwc_pkg::CTRL_WDTE];
  assign gie  = s_q.ctrl[rwc_pkg::CTRL_GIE];
  assign mode = rwc_pkg::rwc_mode_t'(s_q.ctrl[rwc_pkg::CTRL_MODE +: 2]);

  rwc_wdt #(.PERIOD(WDT_CYC)) u_wdt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (wdte),
    .clear   (s_q.wdt_clr),
    .timeout (wdt_to)
  );

  // ---------------------------------------------------------------------
  // wake and interrupt decode per mode
  // ---------------------------------------------------------------------
  assign low_pwr = (mode == rwc_pkg::RWC_SLEEP) ||
                   (mode == rwc_pkg::RWC_IDLE);

  always_comb begin
    wake_any = 1'b0;
    irq_any  = 1'b0;
    // ext pin and pin change wake in sleep and idle
    if (ext_ev && s_q.wake_en[rwc_pkg::WK_EXT])
      wake_any = 1'b1;
    if (chg_ev && s_q.wake_en[rwc_pkg::WK_PIN])
      wake_any = 1'b1;
    // counter-mode timer wakes both; plain timer idle only
    if (tmr_ev && s_q.irq_en[rwc_pkg::IE_TMR] &&
        (s_q.ctrl[rwc_pkg::CTRL_TCNT] || mode == rwc_pkg::RWC_IDLE))
      wake_any = 1'b1;
    // serial events wake idle only
    if (mode == rwc_pkg::RWC_IDLE && s_q.wake_en[rwc_pkg::WK_SER] &&
        (stx_ev || srx_ev || ser_ev))
      wake_any = 1'b1;
    // watchdog on: only resets wake from sleep
    if (wdte && mode == rwc_pkg::RWC_SLEEP)
      wake_any = 1'b0;
    // vectoring needs the individual enable
    irq_any = (ext_ev && s_q.irq_en[rwc_pkg::IE_EXT]) ||
              (chg_ev && s_q.irq_en[rwc_pkg::IE_PIN]) ||
              (tmr_ev && s_q.irq_en[rwc_pkg::IE_TMR]) ||
              (stx_ev && s_q.irq_en[rwc_pkg::IE_STX]) ||
              (srx_ev && s_q.irq_en[rwc_pkg::IE_SRX]) ||
              (ser_ev && s_q.irq_en[rwc_pkg::IE_SER]);
  end

  assign irq_pend = irq_any && !low_pwr;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.vec     = 1'b0;
    s_d.nxt     = 1'b0;
    s_d.wdt_clr = 1'b0;
    s_d.osc     = 1'b1;

    // ahb address phase capture
    s_d.ph_wr = 1'b0;
    s_d.ph_rd = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.ph_wr   = hwrite;
      s_d.ph_rd   = !hwrite;
      s_d.ph_addr = haddr[7:0];
    end

    // ahb write data phase
    if (s_q.ph_wr) begin
      case (s_q.ph_addr)
        rwc_pkg::OFS_CTRL:  s_d.ctrl    = hwdata[rwc_pkg::CTRL_W-1:0];
        rwc_pkg::OFS_WAKE:  s_d.wake_en = hwdata[rwc_pkg::WK_W-1:0];
        rwc_pkg::OFS_IRQEN: s_d.irq_en  = hwdata[rwc_pkg::IE_W-1:0];
        rwc_pkg::OFS_CORE: begin
          s_d.pc   = hwdata[7:0];
          s_d.bank = hwdata[15:8];
        end
        default: ;
      endcase
    end

    // read data registered for the next data phase
    s_d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        rwc_pkg::OFS_CTRL:   s_d.rdata = {27'h0, s_q.ctrl};
        rwc_pkg::OFS_WAKE:   s_d.rdata = {29'h0, s_q.wake_en};
        rwc_pkg::OFS_IRQEN:  s_d.rdata = {26'h0, s_q.irq_en};
        rwc_pkg::OFS_STATUS: s_d.rdata = {26'h0, s_q.st, s_q.rst_out,
                                          s_q.flag_p, s_q.flag_t};
        rwc_pkg::OFS_CORE:   s_d.rdata = {16'h0, s_q.bank, s_q.pc};
        default:             s_d.rdata = 32'h0000_0000;
      endcase
    end

    // sequencing
    case (s_q.st)
      rwc_pkg::RWC_ST_HOLD: begin
        s_d.rst_out = 1'b1;
        s_d.port_in = 1'b1;
        s_d.wdt_clr = 1'b1;
        if (s_q.cnt >= rwc_pkg::CNT_W'(START_CYC - 1)) begin
          s_d.st      = rwc_pkg::RWC_ST_RUN;
          s_d.cnt     = '0;
          s_d.rst_out = 1'b0;
          s_d.port_in = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      rwc_pkg::RWC_ST_RUN: begin
        if (power_down_instruction) begin
          s_d.st      = rwc_pkg::RWC_ST_DOWN;
          s_d.wdt_clr = 1'b1;
          s_d.flag_p  = 1'b0;
          s_d.ctrl[rwc_pkg::CTRL_MODE +: 2] = 2'(rwc_pkg::RWC_SLEEP);
        end else if (mode == rwc_pkg::RWC_IDLE && wake_any) begin
          // idle keeps running; a wake goes through the same delay
          s_d.st   = rwc_pkg::RWC_ST_WAKE;
          s_d.wvec = irq_any;
        end else if (irq_pend) begin
          s_d.vec = gie;
          s_d.nxt = !gie;
        end
      end
      rwc_pkg::RWC_ST_DOWN: begin
        if (wake_any) begin
          s_d.st   = rwc_pkg::RWC_ST_WAKE;
          s_d.wvec = irq_any;
        end
      end
      rwc_pkg::RWC_ST_WAKE: begin
        // one clock of wake-up delay
        s_d.st  = rwc_pkg::RWC_ST_RUN;
        s_d.ctrl[rwc_pkg::CTRL_MODE +: 2] = 2'(rwc_pkg::RWC_NORMAL);
        // vector only if some event with its irq enable set was also seen at the wake
        s_d.vec = gie && s_q.wvec;
        s_d.nxt = !(gie && s_q.wvec);
      end
      rwc_pkg::RWC_ST_PULSE: begin
        // one clock reset from pin or watchdog
        s_d.st      = rwc_pkg::RWC_ST_RUN;
        s_d.rst_out = 1'b0;
        s_d.port_in = 1'b0;
      end
      default: s_d.st = rwc_pkg::RWC_ST_HOLD;
    endcase

    // pin or watchdog reset overrides everything; wake keeps bank/pc
    if (pin_rst || (wdt_to && wdte)) begin
      s_d.st      = rwc_pkg::RWC_ST_PULSE;
      s_d.rst_out = 1'b1;
      s_d.port_in = 1'b1;
      s_d.wdt_clr = 1'b1;
      s_d.pc      = 8'h00;
      s_d.bank    = 8'h00;
      s_d.ctrl    = rwc_pkg::CTRL_RST;
      s_d.wake_en = '0;
      s_d.irq_en  = '0;
      s_d.vec     = 1'b0;
      s_d.nxt     = 1'b0;
      s_d.flag_t  = !(wdt_to && wdte);
      s_d.flag_p  = !(s_q.st == rwc_pkg::RWC_ST_DOWN);
    end

    // vector address registered with the pulse it belongs to
    s_d.vaddr = s_d.vec ? rwc_pkg::VEC_ADDR : 8'h00;
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q          <= '0;
      s_q.st       <= rwc_pkg::RWC_ST_HOLD;
      s_q.ctrl     <= rwc_pkg::CTRL_RST;
      s_q.rst_out  <= 1'b1;
      s_q.port_in  <= 1'b1;
      s_q.osc      <= 1'b1;
      s_q.flag_t   <= 1'b1;
      s_q.flag_p   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  // zero wait states: the bus is never stalled and always answers okay
  assign hrdata              = s_q.rdata;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign core_reset          = s_q.rst_out;
  assign osc_run             = s_q.osc;
  assign port_force_input    = s_q.port_in;
  assign resume_next         = s_q.nxt;
  assign take_vector         = s_q.vec;
  assign vector_addr         = s_q.vaddr;
  assign program_counter_low = s_q.pc;
  assign bank_select         = s_q.bank;
  assign flag_timeout        = s_q.flag_t;
  assign flag_power_down     = s_q.flag_p;

endmodule : rwc_top

// *** rtl/rwc_wdt.sv ***
// Purpose: watchdog counter with a synchronous clear
// Assumes: counts on hclk
// Notes:   timeout is a one-cycle pulse
`timescale 1ns/10ps
module rwc_wdt #(
  parameter int unsigned PERIOD = rwc_pkg::WDT_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enable,
  input  wire logic clear,
  output logic      timeout
);
  logic [rwc_pkg::CNT_W-1:0] cnt_q;

  // ---------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q   <= '0;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (clear || !enable) begin
        cnt_q <= '0;
      end else if (cnt_q == rwc_pkg::CNT_W'(PERIOD - 1)) begin
        cnt_q   <= '0;
        timeout <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : rwc_wdt

// *** tb/rwc_chk_sva.sv ***
// Purpose: checker of the reset and wake outputs of rwc_top
// Assumes: one hclk domain, hresetn asynchronous active low
// Notes:   bound to rwc_top at the foot of this file
`timescale 1ns/10ps
module rwc_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       ext_reset_n,
  input wire logic       core_reset,
  input wire logic       osc_run,
  input wire logic       port_force_input,
  input wire logic       resume_next,
  input wire logic       take_vector,
  input wire logic [7:0] vector_addr,
  input wire logic [7:0] program_counter_low,
  input wire logic [7:0] bank_select
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_vec;
    vector_addr == (take_vector ? rwc_pkg::VEC_ADDR : 8'h00);
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_one; !(take_vector && resume_next); endproperty
  a_one: assert property (p_one) else $error("both wake pulses");
  property p_rsm; resume_next |=> !resume_next; endproperty
  a_rsm: assert property (p_rsm) else $error("resume too long");
  property p_pin; $fell(ext_reset_n) |-> ##[1:4] core_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin reset missed");
  property p_len; $rose(core_reset) |=> !core_reset; endproperty
  a_len: assert property (p_len) else $error("reset not one clock");
  property p_pc;
    $fell(core_reset) |-> program_counter_low == 8'h00 && bank_select == 8'h00;
  endproperty
  a_pc: assert property (p_pc) else $error("pc or bank kept");
  property p_port; core_reset |-> port_force_input; endproperty
  a_port: assert property (p_port) else $error("ports not input");
  property p_osc; osc_run; endproperty
  a_osc: assert property (p_osc) else $error("oscillator stopped");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus answer wrong");
  // main scenarios seen
  c_vec: cover property (take_vector);
  c_rsm: cover property (resume_next);
  c_rst: cover property ($rose(core_reset));
endmodule : rwc_chk
bind rwc_top rwc_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .ext_reset_n(ext_reset_n), .core_reset(core_reset), .osc_run(osc_run),
  .port_force_input(port_force_input), .resume_next(resume_next),
  .take_vector(take_vector), .vector_addr(vector_addr),
  .program_counter_low(program_counter_low), .bank_select(bank_select)
);

// *** tb/rwc_src_model.sv ***
// Purpose: core and wake source model facing rwc_top
// Assumes: bench strobes pd_go and ev_go for one clock
// Notes:   wake events arrive off the clock edge
`timescale 1ns/10ps
module rwc_src_model (
  input  wire logic       hclk,
  input  wire logic       core_reset,
  input  wire logic       pd_go,
  input  wire logic [5:0] ev_go,
  output logic            power_down_instruction,
  output logic      [5:0] ev
);
  logic [5:0] ev_q;
  initial begin
    power_down_instruction = 1'b0;
    ev_q = 6'h00;
    ev = 6'h00;
  end
  // a core held in reset executes nothing
  always @(posedge hclk) begin
    power_down_instruction <= pd_go && !core_reset;
    ev_q <= ev_go;
  end
  // asynchronous sources, so the block must synchronise them
  always @(ev_q) ev <= #13 ev_q;
endmodule : rwc_src_model

// *** tb/rwc_top_tb.sv ***
// Purpose: self-checking bench of rwc_top
// Assumes: hclk 20 MHz, short start and watchdog counts
// Notes:   wake results go through a queue of expected codes
`timescale 1ns/10ps
module rwc_top_tb;
  localparam int ST = 20;
  localparam int WD = 50;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0;
  logic        ext_reset_n = 1, pd_go = 0, cr_q = 1;
  logic [31:0] haddr = 0, hwdata = 0, lfsr = 32'h0000_066d, hrdata;
  logic [1:0]  htrans = 0, res;
  logic [2:0]  hsize = 3'h2;
  logic [5:0]  ev_go = 0, ev;
  logic [7:0]  vector_addr, program_counter_low, bank_select;
  logic        hreadyout, hresp, core_reset, osc_run, port_force_input;
  logic        resume_next, take_vector, flag_timeout, flag_power_down;
  logic        power_down_instruction;
  int          miscompares = 0, compares = 0, cyc = 0;
  logic [31:0] rdq[$];
  logic [1:0]  evq[$];

  always #25 hclk = ~hclk;

  rwc_top #(.START_CYC(ST), .WDT_CYC(WD)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_reset_n(ext_reset_n),
    .power_down_instruction(power_down_instruction),
    .timer_event(ev[0]), .ext_pin_event(ev[1]), .pin_change_event(ev[2]),
    .serial_tx_done(ev[3]), .serial_rx_full(ev[4]),
    .serial_rx_error(ev[5]), .core_reset(core_reset), .osc_run(osc_run),
    .port_force_input(port_force_input), .resume_next(resume_next),
    .take_vector(take_vector), .vector_addr(vector_addr),
    .program_counter_low(program_counter_low), .bank_select(bank_select),
    .flag_timeout(flag_timeout), .flag_power_down(flag_power_down));
  rwc_src_model u_src (
    .hclk(hclk), .core_reset(core_reset), .pd_go(pd_go), .ev_go(ev_go),
    .power_down_instruction(power_down_instruction), .ev(ev));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr_next

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // read data and wake results are taken off the queues as they appear
  always @(posedge hclk) begin
    if (rd_ph && rdq.size() > 0)
      chk(hrdata, rdq.pop_front());
    res = take_vector ? 2'd2 : resume_next ? 2'd1 :
          (core_reset && !cr_q) ? 2'd3 : 2'd0;
    cr_q = core_reset;
    if (hresetn && res != 2'd0)
      chk({30'h0, res}, {30'h0, evq.size() > 0 ? evq.pop_front() : 2'd0});
  end

  // a hang ends the run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    rd_ph <= 1'b0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph <= !wr;
    if (!wr) rdq.push_back(e);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : ahb

  task automatic pdown();
    pd_go <= 1'b1;
    @(posedge hclk);
    pd_go <= 1'b0;
  endtask : pdown

  task automatic settle(input int n);
    tick(n);
    chk(evq.size(), 32'h0);
  endtask : settle

  task automatic do_reset();
    int n;
    n = 0;
    hresetn <= 1'b0;
    tick(3);
    hresetn <= 1'b1;
    while (core_reset !== 1'b0 && n < 1000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk(32'(n >= ST - 1 && n <= ST + 2), 32'h1);
  endtask : do_reset

  // set up one mode, fire one source, then expect the result code
  task automatic run_row(input logic slp, input logic [4:0] c,
                         input logic [2:0] w, input logic [5:0] ie,
                         input int ix, input logic [1:0] ex);
    logic [31:0] r;
    lfsr = lfsr_next(lfsr);
    r = {16'h0000, lfsr[15:0]};
    ahb(1'b1, rwc_pkg::OFS_CORE, r, 32'h0);
    ahb(1'b1, rwc_pkg::OFS_WAKE, {29'h0, w}, 32'h0);
    ahb(1'b1, rwc_pkg::OFS_IRQEN, {26'h0, ie}, 32'h0);
    ahb(1'b1, rwc_pkg::OFS_CTRL, {27'h0, c}, 32'h0);
    if (slp) pdown();
    tick(4);
    ev_go[ix] <= 1'b1;
    if (ex != 2'd0) evq.push_back(ex);
    @(posedge hclk);
    ev_go <= 6'h00;
    settle(12);
    if (ex != 2'd0)
      ahb(1'b0, rwc_pkg::OFS_CORE, 32'h0, r);
    else begin
      evq.push_back(2'd3);
      ext_reset_n <= 1'b0;
      @(posedge hclk);
      ext_reset_n <= 1'b1;
      settle(8);
      if (slp) chk(32'(flag_power_down), 32'h0);
      ahb(1'b0, rwc_pkg::OFS_CORE, 32'h0, 32'h0);
    end
  endtask : run_row

  // main sequence
  initial begin
    do_reset();
    ahb(1'b0, rwc_pkg::OFS_CTRL, 32'h0, {27'h0, rwc_pkg::CTRL_RST});
    ahb(1'b0, rwc_pkg::OFS_WAKE, 32'h0, 32'h0);
    ahb(1'b1, rwc_pkg::OFS_STATUS, 32'hffff_ffff, 32'h0);
    ahb(1'b0, rwc_pkg::OFS_STATUS, 32'h0,
        {26'h0, 3'(rwc_pkg::RWC_ST_RUN), 3'b011});
    lfsr = lfsr_next(lfsr);
    ahb(1'b1, 8'h20, lfsr, 32'h0);
    ahb(1'b0, 8'h20, 32'h0, 32'h0);
    ahb(1'b1, rwc_pkg::OFS_IRQEN, lfsr, 32'h0);
    ahb(1'b0, rwc_pkg::OFS_IRQEN, 32'h0, {26'h0, lfsr[5:0]});
    $display("test registers done");
    // at most one wake source enabled; watchdog off except in the ninth row
    run_row(1, 5'h00, 3'h1, 6'h00, 1, 2'd1);
    run_row(1, 5'h02, 3'h1, 6'h02, 1, 2'd2);
    run_row(1, 5'h02, 3'h0, 6'h02, 1, 2'd0);
    run_row(1, 5'h00, 3'h2, 6'h04, 2, 2'd1);
    run_row(1, 5'h02, 3'h2, 6'h04, 2, 2'd2);
    run_row(1, 5'h02, 3'h0, 6'h01, 0, 2'd0);
    run_row(1, 5'h12, 3'h0, 6'h01, 0, 2'd2);
    run_row(1, 5'h02, 3'h4, 6'h08, 3, 2'd0);
    run_row(1, 5'h01, 3'h1, 6'h02, 1, 2'd0);
    run_row(0, 5'h08, 3'h0, 6'h01, 0, 2'd1);
    run_row(0, 5'h0a, 3'h4, 6'h10, 4, 2'd2);
    run_row(0, 5'h0a, 3'h0, 6'h20, 5, 2'd0);
    run_row(0, 5'h0a, 3'h2, 6'h00, 2, 2'd1);
    run_row(0, 5'h02, 3'h0, 6'h02, 1, 2'd2);
    run_row(0, 5'h00, 3'h2, 6'h00, 2, 2'd0);
    run_row(0, 5'h04, 3'h0, 6'h08, 3, 2'd1);
    run_row(0, 5'h06, 3'h0, 6'h01, 0, 2'd2);
    $display("test wake table done");
    ahb(1'b1, rwc_pkg::OFS_CTRL, 32'h1, 32'h0);
    tick(WD - 10);
    evq.push_back(2'd3);
    settle(25);
    chk(32'(flag_timeout), 32'h0);
    ahb(1'b1, rwc_pkg::OFS_CTRL, 32'h1, 32'h0);
    tick(30);
    pdown();
    tick(40);
    evq.push_back(2'd3);
    settle(30);
    chk({30'h0, flag_timeout, flag_power_down}, 32'h0);
    $display("test watchdog done");
    do_reset();
    ahb(1'b0, rwc_pkg::OFS_CTRL, 32'h0, 32'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule : rwc_top_tb
